// *** rtl/sdc_top.sv ***
// Purpose: converter control and data registers on an AHB-Lite slave
// Assumes: filter result strobe is synchronous to clk_sys_in
// Notes:   zero wait state; hrdata is registered in the address phase
//
// Design decisions made here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "sdc_defines.svh"

module sdc_top
   import sdc_pkg::*;
(
   // clock and reset
   input  wire logic            clk_sys_in,
   input  wire logic            rst_n_in,
   // ahb-lite slave
   input  wire sdc_ahb_req_t    ahb_in,
   output sdc_ahb_rsp_t         ahb_out,
   // filter result
   input  wire logic            result_valid_in,
   input  wire logic [23:0]     result_data_in,
   // amplifier front end
   output sdc_route_t           negative_input_select_out,
   output sdc_route_t           positive_input_select_out,
   output sdc_offset_t          amp_offset_select_out,
   // dac
   output logic [9:0]           dac_code_out,
   output logic                 dac_enable_out,
   output logic                 dac_reference_select_out,
   // converter control
   output sdc_conv_ctrl_t       conv_ctrl_out,
   output logic                 conversion_done_out
);

   sdc_state_t state_reg;
   sdc_state_t state_next;

   // one decoder serves both selectors
   function automatic sdc_route_t route_decode(input logic [3:0] code);
      sdc_route_t r;
      r = '0;
      if (code <= `SDC_SEL_PIN_MAX) begin
         r.pin[code[1:0]] = 1'b1;
      end else if (code == `SDC_SEL_VCM) begin
         r.vcm = 1'b1;
      end else if (code == `SDC_SEL_TEMP) begin
         r.temp = 1'b1;
      end else begin
         r.reserved = 1'b1;
      end
      return r;
   endfunction

   // register read view, unimplemented bits masked to zero
   function automatic logic [7:0] read_mux(input sdc_state_t s,
                                           input logic [7:0] a);
      logic [7:0] d;
      d = '0;
      case (a)
         `SDC_ADR_CHSEL: d = s.chsel;
         `SDC_ADR_DAH:   d = s.dah;
         `SDC_ADR_DAL:   d = s.dal & `SDC_MSK_DAL;   // [RULE10]
         `SDC_ADR_DACC:  d = s.dacc & `SDC_MSK_DACC; // [RULE10]
         `SDC_ADR_RESL:  d = s.result[7:0];          // [RULE11]
         `SDC_ADR_RESM:  d = s.result[15:8];         // [RULE11]
         `SDC_ADR_RESH:  d = s.result[23:16];        // [RULE11]
         `SDC_ADR_CR0:   d = s.cr0;
         `SDC_ADR_CR1:   d = s.cr1 & `SDC_MSK_CR1;   // [RULE10]
         `SDC_ADR_OFS:   d = s.ofs & `SDC_MSK_OFS;   // [RULE10]
         default:        d = '0;
      endcase
      return d;
   endfunction

   logic       addr_phase;
   logic       wr_now;
   logic [7:0] wdata;
   logic       accept;
   logic [2:0] ofs_code;
   logic [3:0] osr_code;
   logic [2:0] div_code;
   logic [4:0] div_factor;
   logic       div_valid;

   assign addr_phase = ahb_in.hsel & ahb_in.htrans[1] & ahb_in.hready;
   assign wr_now     = state_reg.wr_pend;
   assign wdata      = ahb_in.hwdata[7:0];
   assign ofs_code   = state_reg.ofs[3:1];
   assign osr_code   = state_reg.cr0[4:1];
   assign div_code   = state_reg.cr1[7:5];

   // results are taken only while running and not latched
   assign accept = result_valid_in
                 & (state_reg.mode == st_run)         // [RULE12] [RULE13]
                 & ~state_reg.cr1[`SDC_CR1_LATCH];    // [RULE20] [RULE21]

   // reserved divide codes stop the converter clock
   always_comb begin
      div_factor = `SDC_DIV_30;
      div_valid  = 1'b0;
      case (div_code)
         `SDC_CLOCK_DIVIDE_SELECT_30: begin
            div_factor = `SDC_DIV_30;                 // [RULE18]
            div_valid  = 1'b1;
         end
         `SDC_CLOCK_DIVIDE_SELECT_12: begin
            div_factor = `SDC_DIV_12;                 // [RULE18]
            div_valid  = 1'b1;
         end
         default: begin
            div_factor = `SDC_DIV_30;
            div_valid  = 1'b0;
         end
      endcase
   end

   always_comb begin
      state_next = state_reg;
      state_next.eoc_evt = 1'b0;
      state_next.adck_en = 1'b0;

      // data phase of a write
      state_next.wr_pend = 1'b0;
      if (wr_now) begin
         case (state_reg.wr_addr)
            `SDC_ADR_CHSEL: state_next.chsel = wdata;
            `SDC_ADR_OFS:   state_next.ofs = wdata & `SDC_MSK_OFS;
            `SDC_ADR_DAH: begin
               state_next.dah = wdata;
               state_next.dal = state_reg.dal_shadow;   // [RULE7]
            end
            `SDC_ADR_DAL:
               state_next.dal_shadow = wdata & `SDC_MSK_DAL; // [RULE7]
            `SDC_ADR_DACC:  state_next.dacc = wdata & `SDC_MSK_DACC;
            `SDC_ADR_CR0:   state_next.cr0 = wdata;
            `SDC_ADR_CR1:   state_next.cr1 = wdata & `SDC_MSK_CR1;
            default: begin
            end
         endcase
      end

      // hardware set wins over a software clear in the same cycle
      if (accept) begin
         state_next.result = result_data_in;            // [RULE23]
         state_next.cr1[`SDC_CR1_EOC] = 1'b1;           // [RULE22]
         state_next.eoc_evt = 1'b1;
      end

      // power-off first, then sleep, then soft reset
      if (state_next.cr0[`SDC_CR0_OFF]) begin
         state_next.mode = st_off;                      // [RULE14]
      end else if (state_next.cr0[`SDC_CR0_SLP]) begin
         state_next.mode = st_sleep;                    // [RULE13]
      end else if (state_next.cr0[`SDC_CR0_RST]) begin
         state_next.mode = st_reset;                    // [RULE12]
      end else begin
         state_next.mode = st_run;
      end

      // converter clock enable from the divide factor
      if (state_reg.mode == st_off || !div_valid) begin
         state_next.div_cnt = '0;
      end else if (state_reg.div_cnt >= div_factor - `SDC_CNT_ONE) begin
         state_next.div_cnt = '0;
         state_next.adck_en = 1'b1;                     // [RULE18]
      end else begin
         state_next.div_cnt = state_reg.div_cnt + `SDC_CNT_ONE;
      end

      // address phase; read sees the write finishing now
      if (addr_phase) begin
         state_next.wr_pend = ahb_in.hwrite;
         state_next.wr_addr = ahb_in.haddr[7:0];
         if (!ahb_in.hwrite) begin
            state_next.hrdata = {24'h000000,
                                 read_mux(state_next, ahb_in.haddr[7:0])};
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg            <= '0;
         state_reg.chsel      <= `SDC_RST_ZERO;
         state_reg.cr0        <= `SDC_RST_CR0;          // [RULE14]
         state_reg.cr1        <= `SDC_RST_ZERO;
         state_reg.mode       <= st_off;
      end else begin
         state_reg <= state_next;
      end
   end

   // bus answer: always ready, always okay
   assign ahb_out.hrdata    = state_reg.hrdata;
   assign ahb_out.hreadyout = 1'b1;
   assign ahb_out.hresp     = 1'b0;

   // amplifier routing and offset
   assign negative_input_select_out = route_decode(state_reg.chsel[7:4]); // [RULE2]
   assign positive_input_select_out = route_decode(state_reg.chsel[3:0]); // [RULE3]
   assign amp_offset_select_out.negative = ofs_code[2];            // [RULE1]
   assign amp_offset_select_out.quarters = ofs_code[1:0];          // [RULE1]

   // dac
   assign dac_code_out = {state_reg.dah, state_reg.dal[3:2]};      // [RULE6]
   assign dac_enable_out           = state_reg.dacc[`SDC_DACC_EN];  // [RULE9]
   assign dac_reference_select_out = state_reg.dacc[`SDC_DACC_VRS]; // [RULE9]

   // converter controls
   assign conv_ctrl_out.mode = state_reg.mode;
   assign conv_ctrl_out.filter_reset =
      (state_reg.mode == st_off) | state_reg.cr0[`SDC_CR0_RST];    // [RULE12]
   assign conv_ctrl_out.osr =
      (osr_code <= `SDC_OSR_MAX) ? (`SDC_OSR_BASE >> osr_code)
                                 : 16'h0000;                      // [RULE16]
   assign conv_ctrl_out.osr_valid = (osr_code <= `SDC_OSR_MAX);   // [RULE16]
   assign conv_ctrl_out.ref_external = state_reg.cr0[`SDC_CR0_VREF]; // [RULE17]
   assign conv_ctrl_out.div_factor = div_factor;
   assign conv_ctrl_out.div_valid  = div_valid;
   assign conv_ctrl_out.adck_en    = state_reg.adck_en;
   // buffers are dropped in power-off and in sleep alike
   logic mod_awake;
   assign mod_awake = (state_reg.mode == st_run)
                    | (state_reg.mode == st_reset);               // [RULE13]
   assign conv_ctrl_out.bufn_en =
      state_reg.cr1[`SDC_CR1_BUFN] & mod_awake;                   // [RULE19]
   assign conv_ctrl_out.bufp_en =
      state_reg.cr1[`SDC_CR1_BUFP] & mod_awake;                   // [RULE19]
   assign conversion_done_out = state_reg.eoc_evt;                // [RULE21]

   // checks
   logic latch_on;
   logic dah_wr;
   logic dal_wr;
   assign latch_on = state_reg.cr1[`SDC_CR1_LATCH];
   assign dah_wr = wr_now & (state_reg.wr_addr == `SDC_ADR_DAH);
   assign dal_wr = wr_now & (state_reg.wr_addr == `SDC_ADR_DAL);

   sequence s_take;
      accept;
   endsequence

   sequence s_loaded;
      (state_reg.result == $past(result_data_in))
         && state_reg.cr1[`SDC_CR1_EOC] && conversion_done_out;
   endsequence

   result_load_a: assert property (                          // [RULE23]
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      s_take |=> s_loaded)
      else $error("result or flag not loaded after a conversion");

   latch_freeze_a: assert property (                         // [RULE21]
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      latch_on |=> ($stable(state_reg.result) && !conversion_done_out))
      else $error("latched result changed or event raised");

   eoc_sticky_a: assert property (                           // [RULE22]
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      (state_reg.cr1[`SDC_CR1_EOC] && !wr_now) |=>
         state_reg.cr1[`SDC_CR1_EOC])
      else $error("end flag cleared without software");

   dac_copy_a: assert property (                             // [RULE7]
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      dah_wr |=> (state_reg.dal == $past(state_reg.dal_shadow)))
      else $error("shadow not copied on high byte write");

   dal_shadow_a: assert property (                           // [RULE7]
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      dal_wr |=> ($stable(state_reg.dal) && dac_code_out[1:0] ==
                  $past(dac_code_out[1:0])))
      else $error("low write reached the dac directly");

   power_off_a: assert property (                            // [RULE14]
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      state_reg.cr0[`SDC_CR0_OFF] |->
         ((state_reg.mode == st_off) && conv_ctrl_out.filter_reset))
      else $error("power-off did not stop the converter");

   soft_reset_a: assert property (                           // [RULE12]
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      state_reg.cr0[`SDC_CR0_RST] |->
         (conv_ctrl_out.filter_reset && !accept))
      else $error("filter not held in soft reset");

   sleep_mode_a: assert property (                           // [RULE13]
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      (state_reg.cr0[`SDC_CR0_SLP] && !state_reg.cr0[`SDC_CR0_OFF]) |->
         (state_reg.mode == st_sleep))
      else $error("sleep bit did not enter sleep mode");

   sleep_buffers_a: assert property (                        // [RULE13]
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      (state_reg.mode == st_sleep) |->
         !(conv_ctrl_out.bufn_en || conv_ctrl_out.bufp_en))
      else $error("reference buffers on during sleep");

   clk_div_a: assert property (                              // [RULE18]
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      state_reg.adck_en |=> !state_reg.adck_en [*8])
      else $error("converter clock enable too frequent");

   offset_zero_a: assert property (                          // [RULE1]
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      (ofs_code == `SDC_OFS_NEG) |->
         (amp_offset_select_out.quarters == 2'h0))
      else $error("offset code 100 adds an offset");

   osr_low_a: assert property (                              // [RULE16]
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      (osr_code == `SDC_OSR_MAX) |-> (conv_ctrl_out.osr == 16'h0080))
      else $error("code 1000 is not ratio 128");

endmodule // sdc_top

// *** rtl/sdc_defines.svh ***
// Purpose: constants of the converter control register block
// Assumes: AHB-Lite word access, one clock at 100 MHz
// Notes:   the package holds the types; numbers live here
//
// Overview of operation
// RULE1: offset code 000/100 none; 001-011 plus, 101-111 minus quarters
// RULE2: negative selector: 0-3 pins, 1011 common mode, 1100 temp minus
// RULE3: positive selector: 0-3 pins, 1011 common mode, 1100 temp plus
// RULE4: single-ended use puts the opposite selector on common mode
// RULE5: pair the two temperature outputs across both selectors
// RULE6: dac code is high byte then low register bits 3 and 2
// RULE7: low byte goes to a shadow; a high write copies it across
// RULE8: software writes zero to the two low test bits
// RULE9: dac control bit 7 enables, bit 6 picks the reference
// RULE10: unimplemented bits read as zero
// RULE11: result bytes low, middle and high hold bits 7:0, 15:8, 23:16
// RULE12: soft reset holds the filter in reset and drops conversions
// RULE13: sleep leaves only amplifier and bandgap on; clear runs normally
// RULE14: power-off wins over sleep and reset; it resets to one
// RULE15: software sets power-off before the processor idles
// RULE16: oversampling code 0 is 32768, halving per step to code 8
// RULE17: bit 0 of primary control picks internal or external refs
// RULE18: divide code 000 gives 30, 010 gives 12, others reserved
// RULE19: bits 4 and 3 enable the negative and positive ref buffers
// RULE20: bit 2 of secondary control enables result latching
// RULE21: latched results stay frozen, no event, flag unchanged
// RULE22: conversion end sets flag bit 1; only software clears it
// RULE23: all three result bytes load together from one result
`ifndef SDC_DEFINES_SVH
`define SDC_DEFINES_SVH
`define SDC_ADR_CHSEL   8'h00
`define SDC_ADR_DAH     8'h04
`define SDC_ADR_DAL     8'h08
`define SDC_ADR_DACC    8'h0C
`define SDC_ADR_RESL    8'h10
`define SDC_ADR_RESM    8'h14
`define SDC_ADR_RESH    8'h18
`define SDC_ADR_CR0     8'h1C
`define SDC_ADR_CR1     8'h20
`define SDC_ADR_OFS     8'h24
`define SDC_RST_CR0     8'h20
`define SDC_RST_ZERO    8'h00
`define SDC_MSK_DAL     8'h0F
`define SDC_MSK_DACC    8'hC0
`define SDC_MSK_CR1     8'hFE
`define SDC_MSK_OFS     8'h0E
`define SDC_CR0_RST     7
`define SDC_CR0_SLP     6
`define SDC_CR0_OFF     5
`define SDC_CR0_VREF    0
`define SDC_CR1_BUFN    4
`define SDC_CR1_BUFP    3
`define SDC_CR1_LATCH   2
`define SDC_CR1_EOC     1
`define SDC_DACC_EN     7
`define SDC_DACC_VRS    6
`define SDC_SEL_PIN_MAX 4'h3
`define SDC_SEL_VCM     4'hB
`define SDC_SEL_TEMP    4'hC
`define SDC_OFS_NEG     3'h4
`define SDC_OSR_MAX     4'h8
`define SDC_OSR_BASE    16'h8000
`define SDC_CLOCK_DIVIDE_SELECT_30     3'h0
`define SDC_CLOCK_DIVIDE_SELECT_12     3'h2
`define SDC_DIV_30      5'h1E
`define SDC_DIV_12      5'h0C
`define SDC_CNT_ONE     5'h01
`endif

// *** rtl/sdc_pkg.sv ***
// Purpose: types of the converter control register block
// Assumes: constants come from sdc_defines.svh
// Notes:   all carriers are packed structs
package sdc_pkg;
   typedef enum logic [1:0] {st_off, st_sleep, st_reset, st_run} sdc_mode_t;
   typedef struct packed {
      logic        hsel;
      logic [31:0] haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic        hready;
      logic [31:0] hwdata;
   } sdc_ahb_req_t;
   typedef struct packed {
      logic [31:0] hrdata;
      logic        hreadyout;
      logic        hresp;
   } sdc_ahb_rsp_t;
   typedef struct packed {
      logic [3:0] pin;
      logic       vcm;
      logic       temp;
      logic       reserved;
   } sdc_route_t;
   typedef struct packed {
      logic       negative;
      logic [1:0] quarters;
   } sdc_offset_t;
   typedef struct packed {
      sdc_mode_t   mode;
      logic        filter_reset;
      logic [15:0] osr;
      logic        osr_valid;
      logic        ref_external;
      logic [4:0]  div_factor;
      logic        div_valid;
      logic        adck_en;
      logic        bufn_en;
      logic        bufp_en;
   } sdc_conv_ctrl_t;
   typedef struct packed {
      logic [7:0]  chsel;
      logic [7:0]  ofs;
      logic [7:0]  dah;
      logic [7:0]  dal_shadow;
      logic [7:0]  dal;
      logic [7:0]  dacc;
      logic [7:0]  cr0;
      logic [7:0]  cr1;
      logic [23:0] result;
      logic        wr_pend;
      logic [7:0]  wr_addr;
      logic [31:0] hrdata;
      sdc_mode_t   mode;
      logic [4:0]  div_cnt;
      logic        adck_en;
      logic        eoc_evt;
   } sdc_state_t;
endpackage

// *** tb/sdc_filter_model.sv ***
// Purpose: stand-in for the modulator and filter that deliver results
// Assumes: one-cycle result strobe on clk_sys_in, as the block expects
// Notes:   data lines show the inverted last result outside the strobe
`timescale 1ns/1ps

module sdc_filter_model (
   // clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        rst_n_in,
   // command from the bench
   input  wire logic        go_in,
   input  wire logic [23:0] data_in,
   input  wire logic [3:0]  delay_in,
   // result strobe
   output logic             result_valid_out,
   output logic [23:0]      result_data_out
);
   logic [4:0]  cnt_reg;
   logic [23:0] hold_reg;

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_reg          <= 5'h00;
         hold_reg         <= 24'h000000;
         result_valid_out <= 1'b0;
         result_data_out  <= 24'hFFFFFF;
      end else begin
         result_valid_out <= 1'b0;
         // no stale copy of the result outside the strobe
         result_data_out  <= ~hold_reg;
         if (go_in) begin
            cnt_reg  <= {1'b0, delay_in} + 5'h01;
            hold_reg <= data_in;
         end else if (cnt_reg != 5'h00) begin
            cnt_reg <= cnt_reg - 5'h01;
            if (cnt_reg == 5'h01) begin
               result_valid_out <= 1'b1;
               result_data_out  <= hold_reg; // whole word at once
            end
         end
      end
   end
endmodule // sdc_filter_model

// *** tb/sdc_top_test.sv ***
// Purpose: self-checking bench of the converter control registers
// Assumes: zero-wait AHB-Lite slave, filter model on the result side
// Notes:   output checks sample one ns after the clock edge; read data is taken at the edge itself
`timescale 1ns/1ps
`include "sdc_defines.svh"
`define SDC_TB_CHK(got, exp) \
   begin \
      cmp_count++; \
      if ((got) !== (exp)) begin \
         err_count++; \
         $display("Error at %0t: got %0h expected %0h", $time, got, exp); \
      end \
   end

module sdc_top_test
   import sdc_pkg::*;
;
   logic           clk_sys_in = 1'b0;
   logic           rst_n_in   = 1'b0;
   logic           hsel       = 1'b0;
   logic [31:0]    haddr      = 32'h00000000;
   logic [1:0]     htrans     = 2'b00;
   logic           hwrite     = 1'b0;
   logic [31:0]    hwdata     = 32'h00000000;
   logic           go         = 1'b0;
   logic [23:0]    mdata      = 24'h000000;
   logic [3:0]     mdelay     = 4'h0;
   int             err_count  = 0;
   int             cmp_count  = 0;
   int             cycles     = 0;
   sdc_ahb_req_t   ahb_req;
   sdc_ahb_rsp_t   ahb_rsp;
   sdc_route_t     neg_sel;
   sdc_route_t     pos_sel;
   sdc_offset_t    amp_ofs;
   sdc_conv_ctrl_t ctrl;
   logic [9:0]     dac_code;
   logic           dac_en;
   logic           dac_vrs;
   logic           done;
   logic           rvalid;
   logic [23:0]    rdata;

   assign ahb_req = {hsel, haddr, htrans, hwrite, 3'b010,
                     ahb_rsp.hreadyout, hwdata};

   sdc_top dut (
      .clk_sys_in                (clk_sys_in),
      .rst_n_in                  (rst_n_in),
      .ahb_in                    (ahb_req),
      .ahb_out                   (ahb_rsp),
      .result_valid_in           (rvalid),
      .result_data_in            (rdata),
      .negative_input_select_out (neg_sel),
      .positive_input_select_out (pos_sel),
      .amp_offset_select_out     (amp_ofs),
      .dac_code_out              (dac_code),
      .dac_enable_out            (dac_en),
      .dac_reference_select_out  (dac_vrs),
      .conv_ctrl_out             (ctrl),
      .conversion_done_out       (done)
   );

   sdc_filter_model model (
      .clk_sys_in       (clk_sys_in),
      .rst_n_in         (rst_n_in),
      .go_in            (go),
      .data_in          (mdata),
      .delay_in         (mdelay),
      .result_valid_out (rvalid),
      .result_data_out  (rdata)
   );

   always #5 clk_sys_in = ~clk_sys_in;

   task automatic stop_test();
      if (err_count == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // a hang is cut short well above the few hundred cycles needed
   always @(posedge clk_sys_in) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         stop_test();
      end
   end

   task automatic settle();
      @(posedge clk_sys_in);
      #1;
   endtask

   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [7:0] wd, output logic [31:0] rd);
      @(posedge clk_sys_in);
      hsel   <= 1'b1;
      haddr  <= {24'h000000, a};
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge clk_sys_in); while (ahb_rsp.hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= {24'h000000, wd};
      do @(posedge clk_sys_in); while (ahb_rsp.hreadyout !== 1'b1);
      rd = ahb_rsp.hrdata;
      hsel <= 1'b0;
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [31:0] x;
      bus(1'b0, a, 8'h00, x);
      `SDC_TB_CHK(x, {24'h000000, e})
   endtask

   // partner answers dly+1 cycles after it takes go; exp is the done pulse expected
   task automatic send(input logic [23:0] d, input logic [3:0] dly,
                       input logic exp);
      int k;
      @(posedge clk_sys_in);
      go     <= 1'b1;
      mdata  <= d;
      mdelay <= dly;
      @(posedge clk_sys_in);
      go <= 1'b0;
      #1;
      k = 0;
      while (rvalid !== 1'b1 && k < 32) begin
         settle();
         k++;
      end
      settle();
      `SDC_TB_CHK(done, exp)
   endtask

   function automatic sdc_route_t route(input logic [3:0] c);
      route = '0;
      if (c <= 4'h3) route.pin[c[1:0]] = 1'b1;
      else if (c == 4'hB) route.vcm = 1'b1;
      else if (c == 4'hC) route.temp = 1'b1;
      else route.reserved = 1'b1;
   endfunction

   task automatic t_reset();
      logic [7:0] z [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h24, 8'h10};
      foreach (z[i]) rd_chk(z[i], 8'h00);
      rd_chk(`SDC_ADR_CR0, 8'h20);
      rd_chk(`SDC_ADR_CR1, 8'h00);
      `SDC_TB_CHK(ctrl.mode, st_off)
      wr(8'h28, 8'hFF);
      rd_chk(8'h28, 8'h00);
      `SDC_TB_CHK(ahb_rsp.hresp, 1'b0)
   endtask

   task automatic t_front();
      for (int c = 0; c < 16; c++) begin
         wr(`SDC_ADR_CHSEL, {4'(15 - c), 4'(c)});
         `SDC_TB_CHK(pos_sel, route(4'(c)))
         `SDC_TB_CHK(neg_sel, route(4'(15 - c)))
      end
      wr(`SDC_ADR_CHSEL, 8'hB0); // single-ended pin 0 against common mode
      `SDC_TB_CHK({neg_sel.vcm, pos_sel.pin}, 5'h11)
      wr(`SDC_ADR_CHSEL, 8'hCC); // temperature pair on both ends
      `SDC_TB_CHK({neg_sel.temp, pos_sel.temp}, 2'b11)
      for (int c = 0; c < 8; c++) begin
         wr(`SDC_ADR_OFS, {4'hF, 3'(c), 1'b1});
         rd_chk(`SDC_ADR_OFS, {4'h0, 3'(c), 1'b0});
         `SDC_TB_CHK(amp_ofs.quarters, 2'(c))
         if (c % 4 != 0) `SDC_TB_CHK(amp_ofs.negative, 1'(c / 4))
      end
   endtask

   task automatic t_dac();
      wr(`SDC_ADR_DAL, 8'hFC); // test bits kept at zero
      `SDC_TB_CHK(dac_code, 10'h000)
      rd_chk(`SDC_ADR_DAL, 8'h00);
      wr(`SDC_ADR_DAH, 8'hA5);
      `SDC_TB_CHK(dac_code, {8'hA5, 2'b11})
      rd_chk(`SDC_ADR_DAL, 8'h0C);
      wr(`SDC_ADR_DACC, 8'hFF);
      rd_chk(`SDC_ADR_DACC, 8'hC0);
      `SDC_TB_CHK({dac_en, dac_vrs}, 2'b11)
      wr(`SDC_ADR_DACC, 8'h40);
      `SDC_TB_CHK({dac_en, dac_vrs}, 2'b01)
   endtask

   task automatic t_ctrl();
      for (int c = 0; c < 16; c++) begin
         wr(`SDC_ADR_CR0, {3'b000, 4'(c), 1'(c % 2)});
         settle();
         `SDC_TB_CHK(ctrl.osr, (c <= 8) ? 16'h8000 >> c : 16'h0000)
         `SDC_TB_CHK(ctrl.osr_valid, 1'(c <= 8))
         `SDC_TB_CHK(ctrl.ref_external, 1'(c % 2))
      end
      for (int f = 0; f < 8; f++) begin
         wr(`SDC_ADR_CR1, {3'(f), 2'(f), 3'b000});
         settle();
         `SDC_TB_CHK(ctrl.div_valid, 1'(f == 0 || f == 2))
         if (f == 0) `SDC_TB_CHK(ctrl.div_factor, 5'h1E)
         if (f == 2) `SDC_TB_CHK(ctrl.div_factor, 5'h0C)
         `SDC_TB_CHK({ctrl.bufn_en, ctrl.bufp_en}, 2'(f))
      end
   endtask

   task automatic t_adck(input logic [2:0] f, input int n);
      int k;
      wr(`SDC_ADR_CR1, {f, 5'h00});
      settle();
      k = 0;
      while (ctrl.adck_en !== 1'b1 && k < 64) begin
         settle();
         k++;
      end
      k = 0;
      do begin
         settle();
         k++;
      end while (ctrl.adck_en !== 1'b1 && k < 64);
      `SDC_TB_CHK(k, n)
   endtask

   task automatic t_modes();
      logic [7:0] v [5] = '{8'hE0, 8'h40, 8'hC0, 8'h80, 8'h00};
      sdc_mode_t  m [5] = '{st_off, st_sleep, st_sleep, st_reset, st_run};
      logic [4:0] fr = 5'b10110;
      wr(`SDC_ADR_CR1, 8'h58);
      for (int i = 0; i < 5; i++) begin
         wr(`SDC_ADR_CR0, v[i]);
         settle();
         `SDC_TB_CHK(ctrl.mode, m[i])
         `SDC_TB_CHK(ctrl.filter_reset, fr[4 - i])
         `SDC_TB_CHK(ctrl.bufn_en, 1'(i > 2))
         send(24'h123456, 4'h0, 1'(i == 4));
         if (i == 3) rd_chk(`SDC_ADR_RESL, 8'h00);
      end
   endtask

   task automatic t_result();
      rd_chk(`SDC_ADR_RESL, 8'h56);
      rd_chk(`SDC_ADR_RESM, 8'h34);
      rd_chk(`SDC_ADR_RESH, 8'h12);
      rd_chk(`SDC_ADR_CR1, 8'h5A);
      wr(`SDC_ADR_CR1, 8'h5C); // latch on, flag cleared by software
      rd_chk(`SDC_ADR_CR1, 8'h5C);
      send(24'hFEDCBA, 4'h6, 1'b0);
      rd_chk(`SDC_ADR_RESH, 8'h12);
      rd_chk(`SDC_ADR_CR1, 8'h5C);
      wr(`SDC_ADR_CR1, 8'h58);
      send(24'hFEDCBA, 4'h0, 1'b1);
      rd_chk(`SDC_ADR_RESL, 8'hBA);
      rd_chk(`SDC_ADR_RESM, 8'hDC);
      rd_chk(`SDC_ADR_RESH, 8'hFE);
      wr(`SDC_ADR_CR0, 8'h20); // converter off before idling
   endtask

   initial begin
      repeat (12) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      t_reset();
      t_front();
      t_dac();
      t_ctrl();
      t_adck(3'b000, 30);
      t_adck(3'b010, 12);
      t_modes();
      t_result();
      stop_test();
   end
endmodule // sdc_top_test
